// ===== logic/dcbs_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bus switch control block.
// Assumes: 8-bit register pointer on the upstream two-wire bus, 40 MHz core clock.
// Notes: Definitions only.
`ifndef DCBS_REGS_SVH
`define DCBS_REGS_SVH

`define DCBS_REG_STATUS    8'h00
`define DCBS_REG_ACCEL     8'h01
`define DCBS_REG_CONFIG    8'h02
`define DCBS_REG_SWITCH    8'h03

`define DCBS_ACCEL_RST     2'b00
`define DCBS_SWITCH_RST    2'b00
`define DCBS_CONNREQ_RST   1'b0
`define DCBS_MASSWR_RST    1'b1
`define DCBS_TMOSEL_RST    2'b00

`define DCBS_CFG_CONNREQ_BIT 5
`define DCBS_CFG_MASSWR_BIT  2
`define DCBS_CFG_TMO_MSB     1
`define DCBS_CFG_TMO_LSB     0

`define DCBS_TMO_OFF       2'b00
`define DCBS_TMO_30MS      2'b01
`define DCBS_TMO_15MS      2'b10
`define DCBS_TMO_7P5MS     2'b11

`define DCBS_ARA_ADDR      7'h0C
`define DCBS_MASS_ADDR     7'h5E
`define DCBS_BASE_ADDR     7'h40

`define DCBS_CLK_MHZ       40
`define DCBS_TMO_7P5_US    7500
`define DCBS_TMO_BASE_CYC  (`DCBS_TMO_7P5_US * `DCBS_CLK_MHZ)

`endif

// ===== logic/dcbs_pkg.sv
// Purpose: Types shared by the bus switch control block.
// Assumes: Nothing beyond the constant header.
// Notes: Status byte layout is bit 7 down to bit 0.
package dcbs_pkg;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ACK_ADDR = 3'b010,
      ST_RX       = 3'b011,
      ST_ACK_RX   = 3'b100,
      ST_TX       = 3'b101,
      ST_ACK_TX   = 3'b110
   } dcbs_state_t;

   typedef struct packed {
      logic       conn;
      logic       flt1;
      logic       flt2;
      logic [1:0] rsvd;
      logic       no_fail;
      logic       tmo_latched;
      logic       tmo_live;
   } dcbs_status_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } dcbs_line_t;

endpackage

// ===== logic/dcbs_stuck_timer.sv
// Purpose: Stuck-low timeout counter for the upstream clock line.
// Assumes: bus_low_in is already synchronised to clk_in.
// Notes: The live flag stays up until the line goes high or the timeout is disabled.
`timescale 1ns/10ps
`include "dcbs_regs.svh"
module dcbs_stuck_timer import dcbs_pkg::*; #(
   parameter int unsigned BASE_CYC = `DCBS_TMO_BASE_CYC
) (
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       enable_in,
   input  wire logic [1:0] sel_in,
   input  wire logic       bus_low_in,
   output logic            live_out
);
   localparam int CW = 24;
   logic [CW-1:0] count;
   logic [CW-1:0] limit;

   // Code 01 is the longest wait, 11 the shortest.
   always_comb begin
      if (sel_in == `DCBS_TMO_30MS) begin
         limit = CW'(4 * BASE_CYC);
      end else if (sel_in == `DCBS_TMO_15MS) begin
         limit = CW'(2 * BASE_CYC);
      end else begin
         limit = CW'(BASE_CYC);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !enable_in || sel_in == `DCBS_TMO_OFF || !bus_low_in) begin
         count    <= '0;
         live_out <= 1'b0;
      end else if (count == limit - CW'(1)) begin
         live_out <= 1'b1;
      end else begin
         count <= count + CW'(1);
      end
   end

   live_cause_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      live_out |-> $past(bus_low_in) && $past(sel_in) != `DCBS_TMO_OFF)
      else $error("Timeout flag without a low line.");
   live_drop_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !bus_low_in |=> !live_out)
      else $error("Timeout flag outlived the low line.");
endmodule

// ===== logic/dcbs_bus_switch_ctrl.sv
// Purpose: Register slave, switch control and fault reporting of a two-channel bus switch.
// Assumes: Each address select arrives as a two-bit level code: 00 low, 11 high, other floating.
// Notes: Upstream lines are oversampled; the slave never stretches the clock.
`timescale 1ns/10ps
`include "dcbs_regs.svh"
module dcbs_bus_switch_ctrl import dcbs_pkg::*; #(
   parameter int unsigned TMO_BASE_CYC = `DCBS_TMO_BASE_CYC,
   parameter logic [6:0]  BASE_ADDR    = `DCBS_BASE_ADDR
) (
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       enable_in,
   input  wire logic       upstream_clock_line_in,
   input  wire logic       upstream_data_line_in,
   output logic            upstream_data_line_out,
   output logic            upstream_data_line_oe_n_out,
   input  wire logic       downstream_data_ch1_in,
   input  wire logic       downstream_clock_ch1_in,
   input  wire logic       downstream_data_ch2_in,
   input  wire logic       downstream_clock_ch2_in,
   input  wire logic       fault_in_ch1_n_in,
   input  wire logic       fault_in_ch2_n_in,
   input  wire logic [1:0] addr_select_0_in,
   input  wire logic [1:0] addr_select_1_in,
   input  wire logic [1:0] addr_select_2_in,
   output logic            fault_out_n_out,
   output logic            fault_oe_n_out,
   output logic            ready_out,
   output logic            ready_oe_n_out,
   output logic [1:0]      switch_closed_out,
   output logic            upstream_accel_out,
   output logic            downstream_accel_out
);
   localparam int NS = 15;
   logic [NS-1:0] raw;
   logic [NS-1:0] sync1;
   logic [NS-1:0] sync2;
   dcbs_line_t    up;
   dcbs_line_t    up_prev;
   logic          en;
   logic          flt1;
   logic          flt2;
   logic [1:0]    logic_ok;
   logic [6:0]    own_addr;
   logic          start;
   logic          stop;
   logic          rise;
   logic          fall;

   assign raw = {enable_in, upstream_clock_line_in, upstream_data_line_in,
                 downstream_data_ch1_in, downstream_clock_ch1_in,
                 downstream_data_ch2_in, downstream_clock_ch2_in,
                 fault_in_ch1_n_in, fault_in_ch2_n_in,
                 addr_select_2_in, addr_select_1_in, addr_select_0_in};

   // Two flip-flops on every pin before any logic looks at it.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sync1 <= {NS{1'b1}};
         sync2 <= {NS{1'b1}};
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         up_prev <= 2'b11;
      end else begin
         up_prev <= up;
      end
   end

   assign en          = sync2[14];
   assign up          = sync2[13:12];
   assign logic_ok[1] = sync2[11] & sync2[10];
   assign logic_ok[0] = sync2[9] & sync2[8];
   assign flt1        = sync2[7];
   assign flt2        = sync2[6];

   function automatic logic [6:0] lvl(input logic [1:0] code);
      if (code == 2'b00) begin
         lvl = 7'h00;
      end else if (code == 2'b11) begin
         lvl = 7'h02;
      end else begin
         lvl = 7'h01;
      end
   endfunction

   // Base plus a base-three number formed from the three straps.
   assign own_addr = BASE_ADDR + lvl(sync2[1:0]) + lvl(sync2[3:2]) * 7'h03
                     + lvl(sync2[5:4]) * 7'h09;

   assign start = en & up.scl & up_prev.scl & up_prev.sda & ~up.sda;
   assign stop  = en & up.scl & up_prev.scl & ~up_prev.sda & up.sda;
   assign rise  = up.scl & ~up_prev.scl;
   assign fall  = ~up.scl & up_prev.scl;

   dcbs_state_t  state;
   logic [7:0]   sh;
   logic [3:0]   cnt;
   logic [7:0]   ptr;
   logic         rw;
   logic         first;
   logic         ara;
   logic         sda_low;
   logic         wr_stb;
   logic [7:0]   wr_ptr;
   logic [7:0]   wr_data;
   logic [1:0]   accel;
   logic         conn_req;
   logic         mass_en;
   logic [1:0]   tmo_sel;
   logic [1:0]   sw;
   logic         fail_lat;
   logic         tmo_lat;
   logic         tmo_live;
   logic         fault_on;
   logic         addr_hit;
   logic         ara_hit;
   logic [1:0]   allow;
   logic         fail_set;
   logic         clr_stb;
   dcbs_status_t st;
   logic [7:0]   rd_mux;
   logic [7:0]   tx_byte;

   assign fault_on = ~flt1 | ~flt2 | tmo_live | tmo_lat | fail_lat;
   assign ara_hit  = sh[7:1] == `DCBS_ARA_ADDR && sh[0] && fault_on;
   assign addr_hit = sh[7:1] == own_addr || ara_hit
                     || (mass_en && sh[7:1] == `DCBS_MASS_ADDR && !sh[0]);

   assign st = '{conn: |sw, flt1: flt1, flt2: flt2, rsvd: 2'b00, no_fail: ~fail_lat,
                 tmo_latched: tmo_lat, tmo_live: tmo_live};

   always_comb begin
      if (ptr == `DCBS_REG_STATUS) begin
         rd_mux = st;
      end else if (ptr == `DCBS_REG_ACCEL) begin
         rd_mux = {accel, 6'h00};
      end else if (ptr == `DCBS_REG_CONFIG) begin
         rd_mux = {2'b00, conn_req, 2'b00, mass_en, tmo_sel};
      end else if (ptr == `DCBS_REG_SWITCH) begin
         rd_mux = {sw, 2'b00, logic_ok, 2'b00};
      end else begin
         rd_mux = 8'h00;
      end
   end

   // The alert response returns our own address with the read bit set.
   assign tx_byte = ara ? {own_addr, 1'b1} : rd_mux;

   // Two-wire slave; held idle while enable is low.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !en) begin
         state   <= ST_IDLE;
         sh      <= 8'h00;
         cnt     <= 4'h0;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         first   <= 1'b0;
         ara     <= 1'b0;
         sda_low <= 1'b0;
         wr_stb  <= 1'b0;
         wr_ptr  <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (start) begin
            state   <= ST_ADDR;
            cnt     <= 4'h0;
            sda_low <= 1'b0;
         end else if (stop) begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (rise) begin
                     sh  <= {sh[6:0], up.sda};
                     cnt <= cnt + 4'h1;
                  end else if (fall && cnt == 4'h8) begin
                     cnt <= 4'h0;
                     if (state == ST_ADDR) begin
                        if (addr_hit) begin
                           sda_low <= 1'b1;
                           state   <= ST_ACK_ADDR;
                           rw      <= sh[0];
                           first   <= 1'b1;
                           ara     <= ara_hit;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        sda_low <= 1'b1;
                        state   <= ST_ACK_RX;
                        if (first) begin
                           ptr   <= sh;
                           first <= 1'b0;
                        end else begin
                           wr_stb  <= 1'b1;
                           wr_ptr  <= ptr;
                           wr_data <= sh;
                           ptr     <= ptr + 8'h01;
                        end
                     end
                  end
               end
               ST_ACK_ADDR, ST_ACK_RX: begin
                  if (fall) begin
                     if (state == ST_ACK_ADDR && rw) begin
                        state   <= ST_TX;
                        sda_low <= ~tx_byte[7];
                        sh      <= {tx_byte[6:0], 1'b0};
                        ptr     <= ara ? ptr : ptr + 8'h01;
                     end else begin
                        state   <= ST_RX;
                        sda_low <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (rise) begin
                     cnt <= cnt + 4'h1;
                  end else if (fall) begin
                     if (cnt == 4'h8) begin
                        cnt     <= 4'h0;
                        sda_low <= 1'b0;
                        state   <= ST_ACK_TX;
                     end else begin
                        sda_low <= ~sh[7];
                        sh      <= {sh[6:0], 1'b0};
                     end
                  end
               end
               ST_ACK_TX: begin
                  if (rise && up.sda) begin
                     state <= ST_IDLE;
                  end else if (fall) begin
                     state   <= ST_TX;
                     sda_low <= ~tx_byte[7];
                     sh      <= {tx_byte[6:0], 1'b0};
                     ptr     <= ara ? ptr : ptr + 8'h01;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign clr_stb  = wr_stb && wr_ptr == `DCBS_REG_STATUS;
   assign allow    = {2{conn_req}} | logic_ok | sw;
   assign fail_set = wr_stb && wr_ptr == `DCBS_REG_SWITCH && |(wr_data[7:6] & ~allow);

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !en) begin
         accel <= `DCBS_ACCEL_RST;
      end else if (wr_stb && wr_ptr == `DCBS_REG_ACCEL) begin
         accel <= wr_data[7:6];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !en) begin
         conn_req <= `DCBS_CONNREQ_RST;
         mass_en  <= `DCBS_MASSWR_RST;
         tmo_sel  <= `DCBS_TMOSEL_RST;
      end else if (wr_stb && wr_ptr == `DCBS_REG_CONFIG) begin
         conn_req <= wr_data[`DCBS_CFG_CONNREQ_BIT];
         mass_en  <= wr_data[`DCBS_CFG_MASSWR_BIT];
         tmo_sel  <= wr_data[`DCBS_CFG_TMO_MSB:`DCBS_CFG_TMO_LSB];
      end
   end

   // A stuck bus drops both switches; refused channels stay open.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !en) begin
         sw <= `DCBS_SWITCH_RST;
      end else if (tmo_live) begin
         sw <= 2'b00;
      end else if (wr_stb && wr_ptr == `DCBS_REG_SWITCH) begin
         sw <= wr_data[7:6] & allow;
      end
   end

   // Setting wins over a clearing write in the same cycle.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !en) begin
         fail_lat <= 1'b0;
         tmo_lat  <= 1'b0;
      end else begin
         if (fail_set) begin
            fail_lat <= 1'b1;
         end else if (clr_stb) begin
            fail_lat <= 1'b0;
         end
         if (tmo_live) begin
            tmo_lat <= 1'b1;
         end else if (clr_stb) begin
            tmo_lat <= 1'b0;
         end
      end
   end

   dcbs_stuck_timer #(
      .BASE_CYC (TMO_BASE_CYC)
   ) u_timer (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .enable_in  (en),
      .sel_in     (tmo_sel),
      .bus_low_in (~up.scl),
      .live_out   (tmo_live)
   );

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         fault_oe_n_out <= 1'b1;
         ready_oe_n_out <= 1'b0;
      end else begin
         fault_oe_n_out <= ~fault_on;
         ready_oe_n_out <= |sw;
      end
   end

   assign fault_out_n_out             = 1'b0;
   assign ready_out                   = 1'b0;
   assign upstream_data_line_out      = 1'b0;
   assign upstream_data_line_oe_n_out = ~sda_low;
   assign switch_closed_out           = sw;
   assign upstream_accel_out          = accel[1];
   assign downstream_accel_out        = accel[0];

   fault_fwd_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!flt1 || !flt2) |=> !fault_oe_n_out)
      else $error("Channel fault not forwarded.");
   timeout_fault_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      tmo_live |=> !fault_oe_n_out && sw == 2'b00)
      else $error("Timeout did not raise fault or open switches.");
   refuse_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (en && wr_stb && wr_ptr == `DCBS_REG_SWITCH && wr_data[7] && !conn_req && !logic_ok[1] && !sw[1])
      |=> !sw[1] && fail_lat ##1 !fault_oe_n_out)
      else $error("Low channel connection not refused.");
   disable_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !en |=> accel == 2'b00 && sw == 2'b00 && tmo_sel == 2'b00 && mass_en && upstream_data_line_oe_n_out)
      else $error("Registers not held at default while disabled.");
   ready_track_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      ##1 ready_oe_n_out == $past(|sw))
      else $error("Ready output does not follow switch state.");
   tmo_latch_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tmo_lat && en && !clr_stb) |=> tmo_lat)
      else $error("Latched timeout lost without a clear.");
   status_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (clr_stb && !tmo_live && !fail_set) |=> !tmo_lat && !fail_lat && $stable(sw) && $stable(accel))
      else $error("Status write did not clear only the fault latches.");
   fault_release_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (flt1 && flt2 && !tmo_live && !tmo_lat && !fail_lat) |=> fault_oe_n_out)
      else $error("Fault output held with no cause.");
   accel_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (en && wr_stb && wr_ptr == `DCBS_REG_ACCEL)
      |=> upstream_accel_out == $past(wr_data[7]) && downstream_accel_out == $past(wr_data[6]))
      else $error("Accelerator enables not updated.");
endmodule

// ===== bench/dcbs_master.sv
// Purpose: Upstream two-wire bus master model for the switch control block.
// Assumes: Both wires have pull-ups; one bit takes 200 ns on the wire.
// Notes: The clock wire stands high between frames.
`timescale 1ns/10ps
module dcbs_master (
   input  wire logic  sda_in,
   output logic       scl_out,
   output logic       sda_low_out,
   output logic [7:0] byte_out,
   output int         cnt_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
      byte_out = 8'h00;
   end
   // Data moves while the clock is low and is sampled halfway through the high phase.
   task automatic bit_x(input logic b, output logic r);
      #25 sda_low_out = ~b;
      #75 scl_out = 1'b1;
      #50 r = sda_in;
      #50 scl_out = 1'b0;
   endtask
   task automatic start();
      #25 sda_low_out = 1'b0;
      #75 scl_out = 1'b1;
      #100 sda_low_out = 1'b1;
      #100 scl_out = 1'b0;
   endtask
   task automatic stop();
      #25 sda_low_out = 1'b1;
      #75 scl_out = 1'b1;
      #100 sda_low_out = 1'b0;
      #100;
   endtask
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic byte_r(input logic last);
      logic [7:0] d;
      logic       r;
      for (int i = 0; i < 8; i++) begin
         bit_x(1'b1, r);
         d = {d[6:0], r};
      end
      bit_x(last, r);
      byte_out = d;
      cnt_out++;
   endtask
   task automatic scl_hold(input logic lo);
      scl_out = ~lo;
   endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the bus switch control block.
// Assumes: Timeout base shortened to 20 core cycles.
// Notes: Read results are queued and compared when the master returns a byte.
`timescale 1ns/10ps
module tb_top;
   localparam int BASE = 20;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       en = 1'b1;
   logic       d1 = 1'b1;
   logic       d2 = 1'b1;
   logic       f1n = 1'b1;
   logic       f2n = 1'b1;
   logic [1:0] a0 = 2'h0;
   logic [1:0] a1 = 2'h0;
   logic [1:0] a2 = 2'h0;
   logic       c1 = 1'b1;
   logic       c2 = 1'b1;
   logic       scl, m_low, sda_oe_n, flt_n, rdy_n, up, dn, k, ch, fo, ro, uo;
   logic [6:0] own;
   logic [1:0] sw;
   logic [7:0] rd_b;
   logic [7:0] exp_q[$];
   int         rd_n;
   int         bad_count = 0;
   int         tests_run = 0;
   int         cyc = 0;
   wire        sda = ~(m_low | ~sda_oe_n);
   wire  [7:0] pins = {2'h0, flt_n, rdy_n, up, dn, sw};
   dcbs_master m (.sda_in(sda), .scl_out(scl), .sda_low_out(m_low), .byte_out(rd_b), .cnt_out(rd_n));
   dcbs_bus_switch_ctrl #(.TMO_BASE_CYC(BASE)) dut (
      .clk_in(clk), .reset_n_in(rst_n), .enable_in(en), .upstream_clock_line_in(scl),
      .upstream_data_line_in(sda), .upstream_data_line_out(uo), .upstream_data_line_oe_n_out(sda_oe_n),
      .downstream_data_ch1_in(d1), .downstream_clock_ch1_in(c1), .downstream_data_ch2_in(d2),
      .downstream_clock_ch2_in(c2), .fault_in_ch1_n_in(f1n), .fault_in_ch2_n_in(f2n),
      .addr_select_0_in(a0), .addr_select_1_in(a1), .addr_select_2_in(a2), .fault_out_n_out(fo),
      .fault_oe_n_out(flt_n), .ready_out(ro), .ready_oe_n_out(rdy_n), .switch_closed_out(sw),
      .upstream_accel_out(up), .downstream_accel_out(dn));
   always #12.5 clk = ~clk;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   always @(rd_n) check(rd_b, exp_q.pop_front());
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   function automatic int lvl(input logic [1:0] c);
      return (c == 2'b00) ? 0 : (c == 2'b11) ? 2 : 1;
   endfunction
   task automatic wr(input logic [6:0] a, input logic [7:0] p, d, input logic ea);
      logic k0, k1, k2;
      m.start();
      m.byte_w({a, 1'b0}, k0);
      m.byte_w(p, k1);
      m.byte_w(d, k2);
      m.stop();
      check({5'h0, k0, k1, k2}, {5'h0, ea, ea, ea});
   endtask
   task automatic rd(input logic [7:0] p, e);
      m.start();
      m.byte_w({own, 1'b0}, k);
      m.byte_w(p, k);
      m.start();
      m.byte_w({own, 1'b1}, k);
      exp_q.push_back(e);
      m.byte_r(1'b1);
      m.stop();
   endtask
   initial begin
      void'($urandom(32'h5CEE));
      a0 = 2'($urandom);
      a1 = 2'($urandom);
      a2 = 2'($urandom);
      ch = 1'($urandom);
      own = 7'h40 + 7'(lvl(a0) + 3 * lvl(a1) + 9 * lvl(a2));
      tick(10);
      rst_n = 1'b1;
      tick(5);
      check(pins, 8'h20);
      check({5'h0, fo, ro, uo}, 8'h00);
      rd(8'h00, 8'h64);
      wr(own, 8'h01, 8'hFF, 1'b1);
      rd(8'h01, 8'hC0);
      check(pins, 8'h2C);
      wr(own ^ 7'h01, 8'h01, 8'h00, 1'b0);
      $display("test defaults done");
      tick(1);
      f1n = ch;
      f2n = ~ch;
      tick(6);
      check(pins, 8'h0C);
      rd(8'h00, {1'b0, ch, ~ch, 5'h04});
      tick(1);
      f1n = 1'b1;
      f2n = 1'b1;
      tick(6);
      check(pins, 8'h2C);
      $display("test fault inputs done");
      d1 = 1'b0;
      wr(own, 8'h03, 8'h80, 1'b1);
      tick(3);
      check(pins, 8'h0C);
      m.start();
      m.byte_w({7'h0C, 1'b1}, k);
      exp_q.push_back({own, 1'b1});
      m.byte_r(1'b1);
      m.stop();
      rd(8'h00, 8'h60);
      wr(own, 8'h00, 8'hFF, 1'b1);
      tick(3);
      check(pins, 8'h2C);
      d1 = 1'b1;
      d2 = 1'b0;
      wr(own, 8'h03, 8'h80, 1'b1);
      tick(3);
      check(pins, 8'h3E);
      rd(8'h03, 8'h88);
      rd(8'h00, 8'hE4);
      wr(own, 8'h02, 8'h24, 1'b1);
      wr(own, 8'h03, 8'hC0, 1'b1);
      tick(3);
      check(pins, 8'h3F);
      d2 = 1'b1;
      $display("test connect done");
      for (int c = 1; c < 4; c++) begin
         wr(own, 8'h02, 8'h24 | 8'(c), 1'b1);
         tick(1);
         m.scl_hold(1'b1);
         tick(BASE * (1 << (3 - c)) - 6);
         check({7'h0, flt_n}, 8'h01);
         m.scl_hold(1'b0);
         tick(4);
         m.scl_hold(1'b1);
         tick(BASE * (1 << (3 - c)) + 10);
         check(pins, 8'h0C);
         m.scl_hold(1'b0);
         rd(8'h00, 8'h66);
         wr(own, 8'h00, 8'h00, 1'b1);
         tick(3);
         check(pins, 8'h2C);
      end
      $display("test timeout done");
      en = 1'b0;
      tick(6);
      check(pins, 8'h20);
      wr(own, 8'h01, 8'h40, 1'b0);
      tick(1);
      en = 1'b1;
      tick(6);
      rd(8'h02, 8'h04);
      wr(own, 8'h01, 8'h40, 1'b1);
      tick(3);
      check(pins, 8'h24);
      $display("test enable done");
      wr(7'h5E, 8'h01, 8'h80, 1'b1);
      tick(3);
      check(pins, 8'h28);
      c1 = 1'b0;
      c2 = 1'b0;
      m.scl_hold(1'b1);
      tick(BASE * 8);
      check({7'h0, flt_n}, 8'h01);
      m.scl_hold(1'b0);
      tick(4);
      rd(8'h03, 8'h00);
      $display("test line states done");
      report_and_stop();
   end
endmodule
